//--- logic/tdp_master.v
`timescale 1ns/1ps
`include "tdp_consts.vh"
// Behaviour
// RULE1 - Parameter telegram carries six user bytes after the standard bytes.
// RULE2 - Byte 0 equal one requests offset search; it outranks gain calibration.
// RULE3 - Bytes 1 and 2 give gain reference force; zero leaves gain alone.
// RULE4 - Byte 3 zero turns filter off; nonzero selects filter setting.
// RULE5 - Only one telegram module is active, chosen by configuration.
// RULE6 - Full control: command plus reference word out, status plus value back.
// RULE7 - Status module: empty request, reply status then value high, low.
// RULE8 - Extended module: zero byte, status, value high, value low.
// RULE9 - Use feedback-only module only after calibration, no parameter access.
// RULE10 - Command byte meaningful only in full control; 00h is normal.
// RULE11 - Read offset 21h and read gain 29h echo code with value.
// RULE12 - Read type 09h echoes code and returns device type.
// RULE13 - Firmware F9h echoes code; main version high, sub version low.
// RULE14 - Write offset 23h: new offset in reference word, echoed back.
// RULE15 - Write gain 2Bh: new gain in reference word, echoed back.
// RULE16 - Find offset 25h zeroes measurement and returns found offset.
// RULE17 - Calibrate gain 2Dh: force in reference word, gain returned.
// RULE18 - Normal status codes 00h, 02h, 04h, 06h report acquisition quality.
// RULE19 - Reference word signed 16 bits within 32767, high byte first.
// RULE20 - Measured value signed 16 bits within 32767, high byte first.
// RULE21 - Nominal force should scale to 10000.
// RULE22 - Response repeats until command byte changes; 00h returns to status.
module tdp_master (
	input wire clk_sys,
	input wire rst_n,
	// User side
	input wire [1:0] cfg_module,
	input wire prm_start,
	input wire prm_find_offset,
	input wire [15:0] prm_gain_ref,
	input wire [7:0] prm_filter,
	input wire cyc_start,
	input wire [7:0] cmd_code,
	input wire [15:0] cmd_value,
	output reg busy_q,
	output reg rsp_valid_q,
	output reg rsp_match_q,
	output reg [7:0] rsp_status_q,
	output reg [15:0] rsp_value_q,
	output reg [1:0] active_module_q,
	// Link side, byte streams to and from the slave
	output reg tx_valid_q,
	output reg [7:0] tx_data_q,
	output reg tx_prm_q,
	output reg tx_last_q,
	input wire tx_ready,
	input wire rx_valid,
	input wire [7:0] rx_data
);
	// ==========================================
	// States
	localparam ST_IDLE = 3'd0;
	localparam ST_PRM = 3'd1;
	localparam ST_REQ = 3'd2;
	localparam ST_RSP = 3'd3;
	localparam ST_DONE = 3'd4;

	reg [2:0] st_q;
	reg [2:0] idx_q;
	reg [2:0] rx_cnt_q;
	reg [7:0] exp_cmd_q;
	reg [15:0] ref_q;
	reg [1:0] mod_q;
	reg rxv_s1_q, rxv_s2_q;
	reg [7:0] rxd_s1_q, rxd_s2_q;
	reg txr_s1_q, txr_s2_q;
	wire [7:0] store_rd;

	// Parameter bytes are built from the inputs as they go out; send index 0..5
	wire prm_wr = prm_start && (st_q == ST_IDLE);

	function [2:0] rsp_len;
		input [1:0] m;
		begin
			case (m)
			`TDP_MOD_EXT: rsp_len = `TDP_RSP_LEN_EXT; // [RULE8]
			`TDP_MOD_STAT: rsp_len = `TDP_RSP_LEN_STAT; // [RULE7]
			default: rsp_len = `TDP_RSP_LEN_FULL; // [RULE6]
			endcase
		end
	endfunction

	// Clamp to +/-32767, the symmetric range
	function [15:0] clamp16;
		input [15:0] v;
		begin
			clamp16 = (v == 16'h8000) ? `TDP_VALUE_MIN : v; // [RULE19]
		end
	endfunction

	// Offset search overrides gain calibration
	wire [15:0] gain_eff = (prm_find_offset) ? `TDP_ZERO16 : prm_gain_ref; // [RULE2] [RULE3]
	// Byte that follows the one now on the link
	wire [2:0] idx_nx = idx_q + 3'd1;
	reg [7:0] prm_byte;
	always @* begin
		case (idx_nx)
		3'd1: prm_byte = gain_eff[15:8]; // [RULE3]
		3'd2: prm_byte = gain_eff[7:0];
		3'd3: prm_byte = prm_filter; // [RULE4]
		default: prm_byte = `TDP_CMD_NORMAL;
		endcase
	end

	// ==========================================
	// Input synchronisers
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			rxv_s1_q <= 1'b0;
			rxv_s2_q <= 1'b0;
			rxd_s1_q <= `TDP_CMD_NORMAL;
			rxd_s2_q <= `TDP_CMD_NORMAL;
			txr_s1_q <= 1'b0;
			txr_s2_q <= 1'b0;
		end else begin
			rxv_s1_q <= rx_valid;
			rxv_s2_q <= rxv_s1_q;
			rxd_s1_q <= rx_data;
			rxd_s2_q <= rxd_s1_q;
			txr_s1_q <= tx_ready;
			txr_s2_q <= txr_s1_q;
		end
	end

	// Synchronised valid is a level; take one byte per rising edge
	reg rxv_d3_q;
	wire rx_take = rxv_s2_q && !rxv_d3_q;
	wire tx_fire = tx_valid_q && txr_s2_q;
	wire rsp_wr = rx_take && (st_q == ST_RSP);

	// Response bytes kept by position; lead byte read back at the end
	tdp_byte_store u_store (
		.clk_sys(clk_sys),
		.wr_en(rsp_wr),
		.wr_addr(rx_cnt_q),
		.wr_data(rxd_s2_q),
		.rd_addr(`TDP_RSP_LEAD_IDX),
		.rd_data(store_rd)
	);

	// ==========================================
	// Sequencer
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			st_q <= ST_IDLE;
			idx_q <= 3'd0;
			rx_cnt_q <= 3'd0;
			exp_cmd_q <= `TDP_CMD_NORMAL;
			ref_q <= `TDP_ZERO16;
			mod_q <= `TDP_MOD_FULL;
			rxv_d3_q <= 1'b0;
			busy_q <= 1'b0;
			rsp_valid_q <= 1'b0;
			rsp_match_q <= 1'b0;
			rsp_status_q <= `TDP_STAT_OK;
			rsp_value_q <= `TDP_ZERO16;
			active_module_q <= `TDP_MOD_FULL;
			tx_valid_q <= 1'b0;
			tx_data_q <= `TDP_CMD_NORMAL;
			tx_prm_q <= 1'b0;
			tx_last_q <= 1'b0;
		end else begin
			rxv_d3_q <= rxv_s2_q;
			rsp_valid_q <= 1'b0;
			case (st_q)
			ST_IDLE: begin
				idx_q <= 3'd0;
				rx_cnt_q <= 3'd0;
				if (prm_wr) begin
					// Module latched here so only one is ever active
					mod_q <= cfg_module; // [RULE5]
					active_module_q <= cfg_module;
					busy_q <= 1'b1;
					tx_prm_q <= 1'b1;
					tx_valid_q <= 1'b1;
					tx_data_q <= prm_find_offset ? `TDP_FIND_OFS_ON : `TDP_CMD_NORMAL;
					tx_last_q <= 1'b0;
					st_q <= ST_PRM;
				end else if (cyc_start) begin
					busy_q <= 1'b1;
					// Command only meaningful in full control
					exp_cmd_q <= (mod_q == `TDP_MOD_FULL) ? cmd_code : `TDP_CMD_NORMAL; // [RULE10]
					ref_q <= clamp16(cmd_value); // [RULE19]
					if (mod_q == `TDP_MOD_FULL) begin
						tx_valid_q <= 1'b1;
						tx_data_q <= cmd_code; // [RULE6]
						tx_last_q <= 1'b0;
						st_q <= ST_REQ;
					end else begin
						// Empty request in the feedback modules
						st_q <= ST_RSP; // [RULE7] [RULE9]
					end
				end
			end
			ST_PRM: begin
				if (tx_fire) begin
					if (idx_q == `TDP_USER_PRM_LEN - 3'd1) begin // [RULE1]
						tx_valid_q <= 1'b0;
						tx_prm_q <= 1'b0;
						tx_last_q <= 1'b0;
						busy_q <= 1'b0;
						st_q <= ST_IDLE;
					end else begin
						idx_q <= idx_q + 3'd1;
						tx_data_q <= prm_byte; // [RULE3] [RULE4]
						tx_last_q <= (idx_q == `TDP_USER_PRM_LEN - 3'd2);
					end
				end
			end
			ST_REQ: begin
				if (tx_fire) begin
					// Reference word goes high byte first
					if (idx_q == 3'd0) begin
						tx_data_q <= ref_q[15:8]; // [RULE19]
						idx_q <= 3'd1;
					end else if (idx_q == 3'd1) begin
						tx_data_q <= ref_q[7:0];
						tx_last_q <= 1'b1;
						idx_q <= 3'd2;
					end else begin
						tx_valid_q <= 1'b0;
						tx_last_q <= 1'b0;
						st_q <= ST_RSP;
					end
				end
			end
			ST_RSP: begin
				if (rx_take) begin
					rx_cnt_q <= rx_cnt_q + 3'd1;
					if (mod_q == `TDP_MOD_EXT && rx_cnt_q == 3'd0) begin
						// Lead byte lives in the store [RULE8]
					end else if (rx_cnt_q == rsp_len(mod_q) - 3'd3) begin
						rsp_status_q <= rxd_s2_q; // [RULE18]
					end else if (rx_cnt_q == rsp_len(mod_q) - 3'd2) begin
						rsp_value_q[15:8] <= rxd_s2_q; // [RULE20]
					end else begin
						rsp_value_q[7:0] <= rxd_s2_q;
						st_q <= ST_DONE;
					end
				end
			end
			ST_DONE: begin
				rsp_valid_q <= 1'b1; // [RULE22]
				// Echo check; normal command expects a measurement status
				rsp_match_q <= (exp_cmd_q == `TDP_CMD_NORMAL) ? // [RULE15] [RULE16] [RULE17]
					(rsp_status_q[7:3] == 5'd0 && !rsp_status_q[0]) :
					(rsp_status_q == exp_cmd_q); // [RULE11] [RULE12] [RULE13] [RULE14]
				if (mod_q == `TDP_MOD_EXT && store_rd != `TDP_EXT_LEAD) begin
					rsp_match_q <= 1'b0; // [RULE8]
				end
				busy_q <= 1'b0;
				st_q <= ST_IDLE;
			end
			default: st_q <= ST_IDLE;
			endcase
		end
	end
endmodule

//--- logic/tdp_consts.vh
`ifndef TDP_CONSTS_VH
`define TDP_CONSTS_VH
// ==========================================
// Telegram layout
`define TDP_USER_PRM_LEN 3'd6
`define TDP_REQ_LEN_FULL 2'd3
`define TDP_RSP_LEN_FULL 3'd3
`define TDP_RSP_LEN_STAT 3'd3
`define TDP_RSP_LEN_EXT 3'd4
// ==========================================
// Module selection
`define TDP_MOD_FULL 2'd0
`define TDP_MOD_STAT 2'd1
`define TDP_MOD_EXT 2'd2
// ==========================================
// Command codes
`define TDP_CMD_NORMAL 8'h00
`define TDP_CMD_RD_TYPE 8'h09
`define TDP_CMD_RD_OFS 8'h21
`define TDP_CMD_WR_OFS 8'h23
`define TDP_CMD_FIND_OFS 8'h25
`define TDP_CMD_RD_GAIN 8'h29
`define TDP_CMD_WR_GAIN 8'h2B
`define TDP_CMD_CAL_GAIN 8'h2D
`define TDP_CMD_RD_FW 8'hF9
// ==========================================
// Status codes, lead byte, flags and value limits
`define TDP_STAT_OK 8'h00
`define TDP_STAT_OVERFLOW 8'h02
`define TDP_STAT_ERROR 8'h04
`define TDP_STAT_OVERLOAD 8'h06
`define TDP_EXT_LEAD 8'h00
`define TDP_RSP_LEAD_IDX 3'd0
`define TDP_FIND_OFS_ON 8'h01
`define TDP_ZERO16 16'h0000
`define TDP_VALUE_MAX 16'h7FFF
`define TDP_VALUE_MIN 16'h8001
`endif

//--- logic/tdp_byte_store.v
`timescale 1ns/1ps
// ==========================================
// Small byte store, registered read port
module tdp_byte_store (
	input wire clk_sys,
	input wire wr_en,
	input wire [2:0] wr_addr,
	input wire [7:0] wr_data,
	input wire [2:0] rd_addr,
	output reg [7:0] rd_data
);
	reg [7:0] mem [0:7];
	always @(posedge clk_sys) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data <= mem[rd_addr];
	end
endmodule

//--- verif/tdp_props.sv
`timescale 1ns/1ps
// ==========
// Port checks
module tdp_props (
	input wire clk_sys,
	input wire rst_n,
	input wire [1:0] cfg_module,
	input wire prm_start,
	input wire cyc_start,
	input wire busy_q,
	input wire rsp_valid_q,
	input wire [1:0] active_module_q,
	input wire tx_valid_q,
	input wire [7:0] tx_data_q,
	input wire tx_prm_q,
	input wire tx_last_q,
	input wire tx_ready
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	sequence s_go;
		(prm_start || cyc_start) && !busy_q;
	endsequence
	sequence s_wait;
		tx_valid_q && !tx_ready && !$past(tx_ready) && !$past(tx_ready, 2);
	endsequence
	property p_busy; s_go |=> busy_q; endproperty
	a_busy: assert property (p_busy) else $error("no busy");
	property p_cfg; prm_start && !busy_q |=> active_module_q == $past(cfg_module); endproperty
	a_cfg: assert property (p_cfg) else $error("module not latched");
	property p_pulse; rsp_valid_q |=> !rsp_valid_q; endproperty
	a_pulse: assert property (p_pulse) else $error("long pulse");
	property p_hold; s_wait |=> tx_valid_q && $stable(tx_data_q); endproperty
	a_hold: assert property (p_hold) else $error("byte dropped");
	property p_last; tx_last_q |-> tx_valid_q && busy_q; endproperty
	a_last: assert property (p_last) else $error("stray last");
	property p_prm; tx_prm_q |-> tx_valid_q; endproperty
	a_prm: assert property (p_prm) else $error("stray prm");
	property p_mod; active_module_q != 2'h3; endproperty
	a_mod: assert property (p_mod) else $error("bad module");
	property p_fb; tx_valid_q && !tx_prm_q |-> active_module_q == 2'h0; endproperty
	a_fb: assert property (p_fb) else $error("feedback request");
endmodule

//--- verif/tdp_dev.sv
`timescale 1ns/1ps
// ==========
// Slave device model
module tdp_dev #(
	parameter [15:0] TYPE_CODE = 16'h005a, // Arbitrary
	parameter [15:0] FW_VER = 16'h0104
) (
	input wire clk_sys,
	input wire rst_n,
	input wire tx_valid_q,
	input wire [7:0] tx_data_q,
	input wire tx_prm_q,
	input wire tx_last_q,
	input wire poll,
	input wire [1:0] mode,
	input wire [15:0] meas,
	input wire [7:0] stat,
	output reg tx_ready = 0,
	output reg rx_valid = 0,
	output reg [7:0] rx_data = 0,
	output reg [7:0] prm_count = 0
);
	reg [7:0] b [0:7];
	reg [15:0] ofs = 0;
	reg [15:0] gain = 16'h2710;
	reg [7:0] filt = 0;
	task put(input [7:0] d);
		rx_data <= d;
		rx_valid <= 1;
		repeat (4) @(posedge clk_sys);
		rx_valid <= 0;
		rx_data <= ~d; // Released line shows no stale byte
		repeat (4) @(posedge clk_sys);
	endtask
	task serve;
		integer n;
		reg p, l;
		reg [15:0] v;
		reg [7:0] s;
		n = 0;
		l = 0;
		p = tx_prm_q;
		while (tx_valid_q && !l && n < 8) begin
			b[n] = tx_data_q;
			l = tx_last_q;
			repeat ($urandom_range(3)) @(posedge clk_sys); // Slow side
			tx_ready <= 1;
			@(posedge clk_sys);
			tx_ready <= 0;
			repeat (4) @(posedge clk_sys);
			n++;
		end
		if (p) begin
			prm_count <= n;
			if (b[0] == 8'h01) ofs = meas;
			else if ({b[1], b[2]} != 0) gain = {b[1], b[2]};
			filt = b[3];
		end else begin
			if (n == 0) b[0] = 0;
			s = b[0] ? b[0] : stat;
			v = meas - ofs;
			case (b[0])
				8'h09: v = TYPE_CODE;
				8'h21: v = ofs;
				8'h23: ofs = {b[1], b[2]};
				8'h25: ofs = meas;
				8'h29: v = gain;
				8'h2B, 8'h2D: gain = {b[1], b[2]};
				8'hF9: v = FW_VER;
				default: ;
			endcase
			if (b[0] == 8'h23 || b[0] == 8'h25) v = ofs;
			if (b[0] == 8'h2B || b[0] == 8'h2D) v = gain;
			if (mode == 2) put(0);
			put(s);
			put(v[15:8]);
			put(v[7:0]);
		end
	endtask
	always @(posedge clk_sys) if (rst_n && (tx_valid_q || poll)) serve();
endmodule

//--- verif/tension_amp_dp_process_data_test.sv
`timescale 1ns/1ps
module tension_amp_dp_process_data_test;
	localparam [15:0] TYPE = 16'h005a;
	localparam [15:0] FW = 16'h0104;
	reg clk_sys = 0, rst_n = 0, prm_start = 0, prm_find_offset = 0, cyc_start = 0, poll = 0;
	reg [1:0] cfg_module = 0;
	reg [15:0] prm_gain_ref = 0, cmd_value = 0, meas = 0, r, ofs;
	reg [7:0] prm_filter = 0, cmd_code = 0, stat = 0;
	wire busy_q, rsp_valid_q, rsp_match_q, tx_valid_q, tx_prm_q, tx_last_q, tx_ready, rx_valid;
	wire [7:0] rsp_status_q, tx_data_q, rx_data, prm_count;
	wire [15:0] rsp_value_q;
	wire [1:0] active_module_q;
	int fail_count = 0, n_tests = 0, i, j;
	reg [24:0] q [$];
	always #50 clk_sys = ~clk_sys;
	tdp_master DUT (.clk_sys, .rst_n, .cfg_module, .prm_start, .prm_find_offset, .prm_gain_ref,
		.prm_filter, .cyc_start, .cmd_code, .cmd_value, .busy_q, .rsp_valid_q, .rsp_match_q,
		.rsp_status_q, .rsp_value_q, .active_module_q, .tx_valid_q, .tx_data_q, .tx_prm_q,
		.tx_last_q, .tx_ready, .rx_valid, .rx_data);
	tdp_dev #(.TYPE_CODE(TYPE), .FW_VER(FW)) u_dev (.clk_sys, .rst_n, .tx_valid_q, .tx_data_q,
		.tx_prm_q, .tx_last_q, .poll, .mode(active_module_q), .meas, .stat, .tx_ready,
		.rx_valid, .rx_data, .prm_count);
	task chk(input [24:0] s, input [24:0] x, input string n);
		n_tests++;
		if (s !== x) begin
			fail_count++;
			$display("unexpected %s expected %h seen %h", n, x, s);
		end
	endtask
	task end_sim;
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	always @(posedge clk_sys) if (rsp_valid_q === 1'b1) begin
		if (q.size() == 0) chk(0, 1, "extra response");
		else chk({rsp_match_q, rsp_status_q, rsp_value_q}, q.pop_front(), "response");
	end
	task idle;
		repeat (2) @(posedge clk_sys);
		for (i = 0; i < 500 && busy_q !== 1'b0; i++) @(posedge clk_sys);
		if (i == 500) begin
			fail_count++;
			end_sim();
		end
		// Far side still finishes its last handshake after busy drops
		repeat (8) @(posedge clk_sys);
	endtask
	task cyc(input [7:0] c, input [15:0] v, input [7:0] s, input [15:0] x);
		q.push_back({1'b1, s, x});
		cmd_code <= c;
		cmd_value <= v;
		cyc_start <= 1;
		poll <= cfg_module != 0;
		@(posedge clk_sys);
		cyc_start <= 0;
		poll <= 0;
		idle();
		chk({rsp_match_q, rsp_status_q, rsp_value_q}, {1'b1, s, x}, "held");
	endtask
	task prm(input [1:0] m, input f, input [15:0] g);
		cfg_module <= m;
		prm_find_offset <= f;
		prm_gain_ref <= g;
		prm_filter <= $urandom;
		prm_start <= 1;
		@(posedge clk_sys);
		prm_start <= 0;
		idle();
		chk(prm_count, 6, "prm bytes");
		chk(active_module_q, m, "module");
	endtask
	initial begin
		i = $urandom(32'h6a25_f59c);
		repeat (12) @(posedge clk_sys);
		rst_n <= 1;
		@(posedge clk_sys);
		meas = $urandom_range(2000);
		ofs = meas;
		prm(0, 1, 16'h1234);
		cyc(8'h29, 0, 8'h29, 16'h2710);
		cyc(8'h21, 0, 8'h21, ofs);
		for (j = 0; j < 4; j++) begin
			stat = 2 * j;
			meas = ofs + $urandom_range(30000);
			cyc(0, $urandom, stat, meas - ofs);
		end
		r = $urandom_range(32767);
		cyc(8'h23, r, 8'h23, r);
		cyc(8'h21, 0, 8'h21, r);
		meas = $urandom_range(20000);
		cyc(8'h25, 0, 8'h25, meas);
		ofs = meas;
		stat = 0;
		cyc(0, 0, 0, 0);
		r = 1 + $urandom_range(32766);
		cyc(8'h2B, r, 8'h2B, r);
		cyc(8'h2D, 16'h2710, 8'h2D, 16'h2710);
		cyc(8'h09, r, 8'h09, TYPE);
		cyc(8'hF9, 0, 8'hF9, FW);
		prm(0, 0, r);
		cyc(8'h29, 0, 8'h29, r);
		prm(0, 0, 0);
		cyc(8'h29, 0, 8'h29, r);
		for (j = 1; j < 3; j++) begin
			prm(j, 0, 0);
			meas = ofs + $urandom_range(9000);
			cyc(8'h21, 0, 0, meas - ofs);
		end
		chk(q.size(), 0, "pending");
		end_sim();
	end
endmodule
bind tdp_master tdp_props u_props (.clk_sys, .rst_n, .cfg_module, .prm_start, .cyc_start,
	.busy_q, .rsp_valid_q, .active_module_q, .tx_valid_q, .tx_data_q, .tx_prm_q, .tx_last_q,
	.tx_ready);
